/* File: src/afs_fault_status.sv */
// amplifier fault protection and status register bank
// assumes fault inputs and pins synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module afs_fault_status (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic short_to_ground,
    input wire logic short_to_supply,
    input wire logic short_across_load,
    input wire logic over_temp,
    input wire logic gp_pin_in,
    output logic gp_pin_out,
    output logic gp_pin_oe,
    output logic speaker_output_driver_en,
    output logic output_switch_en,
    output logic short_fault,
    output logic over_temp_flag
);
    import afs_pkg::*;

    afs_regbus_if bus ();

    afs_i2c_slave u_i2c (
        .clk_sys(clk_sys),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .bus(bus)
    );

    // ==========================================================
    // register state
    logic [7:0] page, next_page;
    logic power, next_power;
    logic [7:0] pin_ctrl, next_pin_ctrl;
    logic pin_level, next_pin_level;
    logic next_short_fault, next_ot_flag;
    logic next_drv_en, next_switch_en, next_gp_out, next_gp_oe;
    logic short_any, spk_write, pin_write, mode_in;

    function automatic logic hit(input logic [7:0] pg, input logic [7:0] cur,
                                 input logic [7:0] ofs, input logic [7:0] a);
        hit = (pg == cur) && (ofs == a);
    endfunction : hit

    function automatic logic [3:0] pin_mode(input logic [7:0] ctrl);
        pin_mode = ctrl[PIN_MODE_LSB +: 4];
    endfunction : pin_mode

    assign short_any = short_to_ground | short_to_supply | short_across_load;
    assign spk_write = bus.wr && hit(page, PAGE_DRV, SPK_CTRL_OFS, bus.addr);
    assign pin_write = bus.wr && hit(page, PAGE_MAIN, PIN_CTRL_OFS, bus.addr);
    assign mode_in = pin_mode(pin_ctrl) == MODE_INPUT;

    // ==========================================================
    // next values
    always_comb begin
        next_page = page;
        if (bus.wr && bus.addr == PAGE_SEL_OFS) begin
            next_page = bus.wdata;
        end
        // fault beats a host write of 1; no self re-enable
        if (short_any) begin
            next_power = 1'b0; // see RQ2
        end else if (spk_write) begin
            next_power = bus.wdata[POWER_BIT]; // see RQ4, RQ14
        end else begin
            next_power = power;
        end
        if (short_any) begin
            next_short_fault = 1'b1; // see RQ1
        end else if (spk_write && bus.wdata[POWER_BIT]) begin
            next_short_fault = 1'b0;
        end else begin
            next_short_fault = short_fault;
        end
        // over-temperature watch has no enable
        next_ot_flag = over_temp; // see RQ6
        next_drv_en = next_power & ~short_any; // see RQ1
        next_switch_en = next_drv_en & ~over_temp; // see RQ7
        next_pin_ctrl = pin_ctrl;
        if (pin_write) begin
            next_pin_ctrl = bus.wdata;
            next_pin_ctrl[PIN_LEVEL_BIT] = 1'b0;
        end
        // single sampled input pin
        next_pin_level = mode_in ? gp_pin_in : pin_level; // see RQ12, RQ10
        next_gp_oe = pin_mode(next_pin_ctrl) == MODE_OUTPUT; // see RQ8
        next_gp_out = next_pin_ctrl[PIN_OUT_BIT];
    end

    // ==========================================================
    // read mux
    always_comb begin
        bus.rdata = 8'h00;
        if (bus.addr == PAGE_SEL_OFS) begin
            bus.rdata = page;
        end else if (hit(page, PAGE_DRV, SPK_CTRL_OFS, bus.addr)) begin
            bus.rdata[POWER_BIT] = power; // see RQ5
        end else if (hit(page, PAGE_MAIN, OT_FLAG_OFS, bus.addr)) begin
            bus.rdata[OT_BIT] = over_temp_flag; // see RQ7
        end else if (hit(page, PAGE_MAIN, PIN_CTRL_OFS, bus.addr)) begin
            bus.rdata = pin_ctrl;
            bus.rdata[PIN_LEVEL_BIT] = pin_level; // see RQ12
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            page <= PAGE_RST;
            power <= SPK_CTRL_RST[POWER_BIT];
            pin_ctrl <= PIN_CTRL_RST;
            pin_level <= 1'b0;
            short_fault <= 1'b0;
            over_temp_flag <= 1'b0;
            speaker_output_driver_en <= 1'b0;
            output_switch_en <= 1'b0;
            gp_pin_out <= 1'b0;
            gp_pin_oe <= 1'b0;
        end else begin
            page <= next_page;
            power <= next_power;
            pin_ctrl <= next_pin_ctrl;
            pin_level <= next_pin_level;
            short_fault <= next_short_fault;
            over_temp_flag <= next_ot_flag;
            speaker_output_driver_en <= next_drv_en;
            output_switch_en <= next_switch_en;
            gp_pin_out <= next_gp_out;
            gp_pin_oe <= next_gp_oe;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence short_seen;
        short_any;
    endsequence

    sequence host_power_on;
        spk_write && bus.wdata[POWER_BIT] && !short_any;
    endsequence

    sequence pin_sampling;
        mode_in && !pin_write;
    endsequence

    short_clears_a: assert property (short_seen |=> !power) // see RQ2
        else $error("power bit not cleared by short");

    driver_off_a: assert property ( // see RQ1
        short_seen |=> !speaker_output_driver_en && !output_switch_en)
        else $error("driver still on after short");

    fault_flag_a: assert property (short_seen |=> short_fault) // see RQ1
        else $error("fault flag not raised");

    power_write_a: assert property ( // see RQ4
        spk_write && !short_any |=> power == $past(bus.wdata[POWER_BIT]))
        else $error("power bit write lost");

    no_self_on_a: assert property ( // see RQ14
        $rose(power) |-> $past(spk_write && bus.wdata[POWER_BIT]))
        else $error("power bit set without host write");

    power_on_a: assert property ( // see RQ4
        host_power_on ##1 !short_any |=> speaker_output_driver_en)
        else $error("driver not enabled after host write");

    hot_stop_a: assert property ( // see RQ7
        over_temp |=> !output_switch_en && over_temp_flag)
        else $error("switching not stopped when hot");

    hot_flag_a: assert property (!over_temp |=> !over_temp_flag) // see RQ6
        else $error("over-temperature flag stuck");

    pin_capture_a: assert property ( // see RQ12
        mode_in |=> pin_level == $past(gp_pin_in))
        else $error("pin level not captured");

    pin_input_a: assert property (pin_sampling |=> !gp_pin_oe) // see RQ8
        else $error("pin driven while in input mode");

    short_wins_a: assert property ( // see RQ14
        spk_write && short_any |=> !power && short_fault)
        else $error("host write beat a short");

    fault_held_a: assert property ( // see RQ14
        short_fault && !spk_write |=> short_fault)
        else $error("fault flag cleared without host write");

    pin_hold_a: assert property (!mode_in |=> $stable(pin_level)) // see RQ12
        else $error("pin level moved outside input mode");

    // enables never lead the power bit
    driver_gate_a: assert property ( // see RQ1
        speaker_output_driver_en |-> power)
        else $error("driver on with power bit clear");

    switch_gate_a: assert property ( // see RQ7
        output_switch_en |-> speaker_output_driver_en && !over_temp_flag)
        else $error("switching while driver off or hot");

    reserved_zero_a: assert property ( // see RQ5
        hit(page, PAGE_DRV, SPK_CTRL_OFS, bus.addr)
        |-> bus.rdata[7:2] == 6'h00 && !bus.rdata[0])
        else $error("reserved bits read nonzero");

    pin_drive_a: assert property ( // see RQ8
        gp_pin_oe |-> gp_pin_out == pin_ctrl[PIN_OUT_BIT])
        else $error("pin output value wrong");
endmodule : afs_fault_status
`default_nettype wire

/* File: src/afs_pkg.sv */
// constants of the amplifier fault and status block
// assumes one clock domain and an i2c register port
// How it works
// (RQ1) Any short powers the driver down and raises a fault flag.
// (RQ2) Any short clears the power bit, bit 1 of register 0x2D on page 1.
// (RQ3) The host spots a fault by reading the power bit as 0 while it runs.
// (RQ4) The power bit is read/write, resets to 0, and 1 powers the driver.
// (RQ5) Other bits of that register are reserved, read 0 and written as 0.
// (RQ6) Over-temperature protection is always active, with no disable.
// (RQ7) Over-heat stops switching and sets read-only bit 7 of reg 45, page 0.
// (RQ8) The general-purpose pin can be an input that samples a comparator.
// (RQ9) The external comparator holds the pin high, low on a load fault.
// (RQ10) Only one general-purpose input exists, so one comparator reaches it.
// (RQ11) For open load the host clears power, then puts 0x08 in pin control.
// (RQ12) In input mode bit 1 of pin control tracks the pin on every clock.
// (RQ13) After sensing the host sets power back to 1 once faults are fixed.
// (RQ14) After a short the power bit stays 0 until the host writes 1.
package afs_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] PAGE_SEL_OFS = 8'h00;
    localparam logic [7:0] SPK_CTRL_OFS = 8'h2D;
    localparam logic [7:0] OT_FLAG_OFS = 8'h2D;
    localparam logic [7:0] PIN_CTRL_OFS = 8'h34;
    localparam logic [7:0] PAGE_MAIN = 8'h00;
    localparam logic [7:0] PAGE_DRV = 8'h01;
    // ==========================================================
    // fields and reset values
    localparam int POWER_BIT = 1;
    localparam int OT_BIT = 7;
    localparam int PIN_LEVEL_BIT = 1;
    localparam int PIN_OUT_BIT = 0;
    localparam int PIN_MODE_LSB = 2;
    localparam logic [3:0] MODE_INPUT = 4'h2;
    localparam logic [3:0] MODE_OUTPUT = 4'h3;
    localparam logic [7:0] SPK_CTRL_RST = 8'h00;
    localparam logic [7:0] PIN_CTRL_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    // ==========================================================
    // i2c
    localparam logic [6:0] DEV_ADDR = 7'h18;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : afs_pkg

/* File: src/afs_regbus_if.sv */
// byte-wide register port between i2c slave and register bank
// assumes one clock; wr is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface afs_regbus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    modport master (output addr, output wdata, output wr, input rdata);
    modport slave (input addr, input wdata, input wr, output rdata);
endinterface : afs_regbus_if
`default_nettype wire

/* File: src/afs_i2c_slave.sv */
// i2c slave: pointer write, data write with auto-increment, reads
// assumes scl and sda synchronous to clk_sys and oversampled
`timescale 1ns/1ps
`default_nettype none
module afs_i2c_slave (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    afs_regbus_if.master bus
);
    import afs_pkg::*;

    typedef enum {S_IDLE, S_ADDR, S_REG, S_WDATA, S_RDATA, S_RACK} afs_i2c_st_t;

    afs_i2c_st_t state, next_state;
    logic [7:0] sh, next_sh, ptr, next_ptr;
    logic [3:0] cnt, next_cnt;
    logic ack, next_ack, oe, next_oe, wr, next_wr;
    logic scl_q, sda_q;
    logic start, stop, rise, fall;

    assign start = scl_in & scl_q & sda_q & ~sda_in;
    assign stop = scl_in & scl_q & ~sda_q & sda_in;
    assign rise = scl_in & ~scl_q;
    assign fall = ~scl_in & scl_q;

    always_comb begin
        next_state = state;
        next_sh = sh;
        next_ptr = ptr;
        next_cnt = cnt;
        next_ack = ack;
        next_oe = oe;
        next_wr = 1'b0;
        if (start) begin
            next_state = S_ADDR;
            next_cnt = 4'h0;
            next_ack = 1'b0;
            next_oe = 1'b0;
        end else if (stop) begin
            next_state = S_IDLE;
            next_ack = 1'b0;
            next_oe = 1'b0;
        end else begin
            case (state)
                S_ADDR, S_REG, S_WDATA: begin
                    if (rise && !ack) begin
                        next_sh = {sh[6:0], sda_in};
                        next_cnt = cnt + 4'h1;
                    end else if (fall && ack) begin
                        // end of our ack bit
                        next_ack = 1'b0;
                        next_oe = 1'b0;
                        next_cnt = 4'h0;
                        if (state == S_ADDR && sh[0]) begin
                            next_state = S_RDATA;
                            next_sh = bus.rdata;
                            next_oe = ~bus.rdata[7];
                            next_cnt = 4'h1;
                        end else if (state == S_ADDR) begin
                            next_state = S_REG;
                        end else if (state == S_REG) begin
                            next_state = S_WDATA;
                        end else begin
                            next_ptr = ptr + 8'h01;
                        end
                    end else if (fall && cnt == BITS_PER_BYTE) begin
                        if (state == S_ADDR && sh[7:1] != DEV_ADDR) begin
                            next_state = S_IDLE;
                        end else begin
                            next_ack = 1'b1;
                            next_oe = 1'b1;
                            if (state == S_REG) begin
                                next_ptr = sh;
                            end
                            if (state == S_WDATA) begin
                                next_wr = 1'b1;
                            end
                        end
                    end
                end
                S_RDATA: begin
                    if (fall && cnt == BITS_PER_BYTE) begin
                        next_oe = 1'b0;
                        next_ack = 1'b0;
                        next_state = S_RACK;
                    end else if (fall) begin
                        next_sh = {sh[6:0], 1'b0};
                        next_oe = ~sh[6];
                        next_cnt = cnt + 4'h1;
                    end
                end
                S_RACK: begin
                    if (rise && sda_in) begin
                        next_state = S_IDLE;
                    end else if (rise) begin
                        next_ack = 1'b1;
                        next_ptr = ptr + 8'h01;
                    end else if (fall && ack) begin
                        next_ack = 1'b0;
                        next_state = S_RDATA;
                        next_sh = bus.rdata;
                        next_oe = ~bus.rdata[7];
                        next_cnt = 4'h1;
                    end
                end
                default: begin
                    next_state = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= S_IDLE;
            sh <= 8'h00;
            ptr <= 8'h00;
            cnt <= 4'h0;
            ack <= 1'b0;
            oe <= 1'b0;
            wr <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            state <= next_state;
            sh <= next_sh;
            ptr <= next_ptr;
            cnt <= next_cnt;
            ack <= next_ack;
            oe <= next_oe;
            wr <= next_wr;
            scl_q <= scl_in;
            sda_q <= sda_in;
            sda_out <= 1'b0;
        end
    end

    assign sda_oe = oe;
    assign bus.addr = ptr;
    assign bus.wdata = sh;
    assign bus.wr = wr;
endmodule : afs_i2c_slave
`default_nettype wire

/* File: test/afs_host_model.sv */
// i2c host processor and external load comparator model
// assumes open-drain sda with pull-up; host moves lines at clk_sys fall
`timescale 1ns/1ps
`default_nettype none
module afs_host_model (
    input wire logic clk_sys,
    input wire logic sda_oe,
    input wire logic load_fault,
    output logic scl_line,
    output logic sda_line,
    output logic cmp_level
);
    import afs_pkg::*;
    localparam int HALF = 4;
    logic master_low = 1'b0;
    initial scl_line = 1'b1;
    // ==========================================================
    // wire levels
    // pull-up wins unless some party pulls low
    assign sda_line = ~(master_low | sda_oe);
    // comparator output high while the load is fine
    assign cmp_level = ~load_fault;
    // ==========================================================
    // bit level
    task automatic pause(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : pause
    task automatic start_cond;
        master_low = 1'b0;
        pause(HALF);
        scl_line = 1'b1;
        pause(HALF);
        master_low = 1'b1;
        pause(HALF);
        scl_line = 1'b0;
        pause(HALF);
    endtask : start_cond
    task automatic stop_cond;
        master_low = 1'b1;
        pause(HALF);
        scl_line = 1'b1;
        pause(HALF);
        master_low = 1'b0;
        pause(2 * HALF);
    endtask : stop_cond
    // one scl pulse, wire sampled in the middle of the high phase
    task automatic clock_bit(input logic drive_low, output logic seen);
        master_low = drive_low;
        pause(HALF);
        scl_line = 1'b1;
        pause(HALF);
        seen = sda_line;
        pause(HALF);
        scl_line = 1'b0;
        pause(HALF);
    endtask : clock_bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(~b[i], seen);
        end
        clock_bit(1'b0, seen);
        ack = ~seen;
    endtask : send_byte
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b0, seen);
            b[i] = seen;
        end
        clock_bit(~last, seen);
    endtask : get_byte
    // ==========================================================
    // register level
    // callers write only zero into reserved bits
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data,
                             output logic ok);
        logic a0, a1, a2;
        start_cond;
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(ofs, a1);
        send_byte(data, a2);
        stop_cond;
        ok = a0 & a1 & a2;
    endtask : write_reg
    // the host learns of a fault only by reading back
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data);
        logic a;
        start_cond;
        send_byte({DEV_ADDR, 1'b0}, a);
        send_byte(ofs, a);
        start_cond;
        send_byte({DEV_ADDR, 1'b1}, a);
        get_byte(1'b1, data);
        stop_cond;
    endtask : read_reg
    task automatic probe_addr(input logic [6:0] dev, output logic ack);
        start_cond;
        send_byte({dev, 1'b0}, ack);
        stop_cond;
    endtask : probe_addr
endmodule : afs_host_model
`default_nettype wire

/* File: test/tb_amp_fault_status.sv */
// self-checking bench of the amplifier fault and status block
// assumes the host model drives the i2c lines and the comparator
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    fails++; $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end end
module tb_amp_fault_status;
    import afs_pkg::*;
    localparam int LIMIT = 80000;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [2:0] shorts = 3'h0;
    logic over_temp = 1'b0;
    logic load_fault = 1'b0;
    logic scl_line, sda_line, sda_oe, cmp_level, gp_pin_oe, gp_pin_out;
    logic drv_en, sw_en, short_fault, ot_flag, sda_out;
    logic [7:0] rd;
    logic ok;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    always #2 clk_sys = ~clk_sys;
    afs_fault_status u_dut (.clk_sys(clk_sys), .reset(reset),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe),
        .short_to_ground(shorts[0]), .short_to_supply(shorts[1]),
        .short_across_load(shorts[2]), .over_temp(over_temp),
        .gp_pin_in(cmp_level), .gp_pin_out(gp_pin_out),
        .gp_pin_oe(gp_pin_oe),
        .speaker_output_driver_en(drv_en), .output_switch_en(sw_en),
        .short_fault(short_fault), .over_temp_flag(ot_flag));
    afs_host_model u_host (.clk_sys(clk_sys), .sda_oe(sda_oe),
        .load_fault(load_fault), .scl_line(scl_line), .sda_line(sda_line),
        .cmp_level(cmp_level));
    // ==========================================================
    // helpers
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= LIMIT) begin
            fails++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        u_host.write_reg(ofs, data, ok);
        `CHK(ok, 1'b1)
        u_host.pause(4);
    endtask : wr
    // ==========================================================
    // scenarios
    task automatic reset_state;
        `CHK({drv_en, sw_en, short_fault, ot_flag}, 4'h0)
        `CHK({sda_out, gp_pin_out, gp_pin_oe}, 3'h0)
        u_host.probe_addr(DEV_ADDR + 7'h01, ok);
        `CHK(ok, 1'b0)
        wr(PAGE_SEL_OFS, PAGE_DRV);
        u_host.read_reg(SPK_CTRL_OFS, rd);
        `CHK(rd, 8'h00)
        u_host.read_reg(8'h10, rd);
        `CHK(rd, 8'h00)
    endtask : reset_state
    task automatic power_up;
        wr(SPK_CTRL_OFS, 8'h02);
        `CHK({drv_en, sw_en}, 2'h3)
        u_host.read_reg(SPK_CTRL_OFS, rd);
        `CHK(rd, 8'h02)
    endtask : power_up
    task automatic short_case(input int k);
        shorts[k] = 1'b1;
        u_host.pause(3);
        `CHK({drv_en, sw_en, short_fault}, 3'h1)
        u_host.read_reg(SPK_CTRL_OFS, rd);
        `CHK(rd, 8'h00)
        shorts = 3'h0;
        u_host.pause(20);
        u_host.read_reg(SPK_CTRL_OFS, rd);
        `CHK(rd, 8'h00)
        `CHK({drv_en, short_fault}, 2'h1)
        wr(SPK_CTRL_OFS, 8'h02);
        `CHK({drv_en, short_fault}, 2'h2)
    endtask : short_case
    task automatic heat_case;
        wr(PAGE_SEL_OFS, PAGE_MAIN);
        over_temp = 1'b1;
        u_host.pause(3);
        `CHK({sw_en, ot_flag}, 2'h1)
        `CHK(drv_en, 1'b1)
        u_host.read_reg(OT_FLAG_OFS, rd);
        `CHK(rd, 8'h80)
        over_temp = 1'b0;
        u_host.pause(3);
        `CHK({sw_en, ot_flag}, 2'h2)
        u_host.read_reg(OT_FLAG_OFS, rd);
        `CHK(rd, 8'h00)
    endtask : heat_case
    task automatic pin_drive_case;
        wr(PAGE_SEL_OFS, PAGE_MAIN);
        wr(PIN_CTRL_OFS, 8'h0D);
        `CHK({gp_pin_oe, gp_pin_out}, 2'h3)
        wr(PIN_CTRL_OFS, 8'h00);
        `CHK({gp_pin_oe, gp_pin_out}, 2'h0)
    endtask : pin_drive_case
    task automatic open_load_case;
        wr(PAGE_SEL_OFS, PAGE_DRV);
        wr(SPK_CTRL_OFS, 8'h00);
        `CHK(drv_en, 1'b0)
        wr(PAGE_SEL_OFS, PAGE_MAIN);
        wr(PIN_CTRL_OFS, 8'h08);
        `CHK(gp_pin_oe, 1'b0)
        u_host.read_reg(PIN_CTRL_OFS, rd);
        `CHK(rd[PIN_LEVEL_BIT], 1'b1)
        load_fault = 1'b1;
        u_host.read_reg(PIN_CTRL_OFS, rd);
        `CHK(rd[PIN_LEVEL_BIT], 1'b0)
        load_fault = 1'b0;
        u_host.read_reg(PIN_CTRL_OFS, rd);
        `CHK(rd[PIN_LEVEL_BIT], 1'b1)
        wr(PAGE_SEL_OFS, PAGE_DRV);
        wr(SPK_CTRL_OFS, 8'h02);
        `CHK(drv_en, 1'b1)
    endtask : open_load_case
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        reset_state();
        power_up();
        for (int k = 0; k < 3; k++) begin
            short_case(k);
        end
        heat_case();
        pin_drive_case();
        open_load_case();
        conclude();
    end
endmodule : tb_amp_fault_status
`default_nettype wire
